/* verilog/rwc_pkg.sv */
// rwc_pkg: constants for the reset and wake cause flag block
// assumes one system clock; no software-visible registers here
package rwc_pkg;
	// power-on values of the two cause flags
	localparam logic RST_TIMEOUT = 1'h1;
	localparam logic RST_POWERDOWN = 1'h1;
	// low pulse on the reset pin is taken after this many low cycles
	localparam int PIN_LOW_MIN = 1;
	localparam logic [1:0] CNT_ONE = 2'h1;
	// operating mode versus sleep
	typedef enum logic {RWC_RUN, RWC_SLEEP} rwc_mode_t;
endpackage : rwc_pkg

/* verilog/rwc_edge_if.sv */
// rwc_edge_if: carries the pin pulse detector result to the flag logic
// assumes the detector and the flag logic share i_clk
`timescale 1ns/1ps
`default_nettype none
interface rwc_edge_if;
	logic pulse;
	modport src (output pulse);
	modport dst (input pulse);
endinterface : rwc_edge_if
`default_nettype wire

/* verilog/rwc_pin_pulse.sv */
// rwc_pin_pulse: finds a high-low-high pulse on the active-low reset pin
// assumes the pin is synchronous to i_clk
`timescale 1ns/1ps
`default_nettype none
module rwc_pin_pulse (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_sys_rst,
	// pin level
	input wire logic i_reset_pin_n,
	// result
	rwc_edge_if.src o_ev
);
	logic seen_low_r;
	logic seen_low_nxt;
	logic pulse_r;
	logic pulse_nxt;

	always_comb begin
		seen_low_nxt = ~i_reset_pin_n;
		// pulse counts on the return high, so a held-low pin fires once
		pulse_nxt = seen_low_r & i_reset_pin_n;
	end

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			seen_low_r <= 1'b0;
			pulse_r <= 1'b0;
		end else begin
			seen_low_r <= seen_low_nxt;
			pulse_r <= pulse_nxt;
		end
	end

	assign o_ev.pulse = pulse_r;
endmodule : rwc_pin_pulse
`default_nettype wire

/* verilog/rwc_flags.sv */
// rwc_flags: timeout and powerdown cause flags, set by reset and wake events
// assumes event inputs are one-cycle pulses synchronous to i_clk
// i_sys_rst is the power-on reset; other resets are event inputs
`timescale 1ns/1ps
`default_nettype none
module rwc_flags (
	// clock and power-on reset
	input wire logic i_clk,
	input wire logic i_sys_rst,
	// reset and wake sources
	input wire logic i_reset_pin_n,
	input wire logic i_watchdog_timer_timeout,
	input wire logic i_pin_change_wake,
	// instruction strobes
	input wire logic i_watchdog_clear_instr,
	input wire logic i_sleep_instr,
	// cause flags and state
	output logic o_timeout_flag,
	output logic o_powerdown_flag,
	output logic o_sleeping,
	output logic o_core_reset
);
	rwc_edge_if pin_ev ();

	rwc_pin_pulse u_pin (
		.i_clk(i_clk),
		.i_sys_rst(i_sys_rst),
		.i_reset_pin_n(i_reset_pin_n),
		.o_ev(pin_ev)
	);

	logic to_r;
	logic to_nxt;
	logic pd_r;
	logic pd_nxt;
	logic crst_r;
	logic crst_nxt;
	rwc_pkg::rwc_mode_t mode_r;
	rwc_pkg::rwc_mode_t mode_nxt;
	logic pin_rst;

	assign pin_rst = pin_ev.pulse;

	// priority: resets, then wakes, then instructions; events are rare
	// and simultaneous ones resolve toward the reset meaning
	always_comb begin
		to_nxt = to_r;
		pd_nxt = pd_r;
		mode_nxt = mode_r;
		crst_nxt = pin_rst | i_watchdog_timer_timeout;
		unique case (mode_r)
			rwc_pkg::RWC_RUN: begin
				if (pin_rst) begin
					// both flags hold
				end else if (i_watchdog_timer_timeout) begin
					to_nxt = 1'b0;
				end else if (i_sleep_instr) begin
					to_nxt = 1'b1;
					pd_nxt = 1'b0;
					mode_nxt = rwc_pkg::RWC_SLEEP;
				end else if (i_watchdog_clear_instr) begin
					to_nxt = 1'b1;
					pd_nxt = 1'b1;
				end
			end
			rwc_pkg::RWC_SLEEP: begin
				if (pin_rst) begin
					to_nxt = 1'b1;
					pd_nxt = 1'b0;
					mode_nxt = rwc_pkg::RWC_RUN;
				end else if (i_watchdog_timer_timeout) begin
					to_nxt = 1'b0;
					pd_nxt = 1'b0;
					mode_nxt = rwc_pkg::RWC_RUN;
				end else if (i_pin_change_wake) begin
					to_nxt = 1'b1;
					pd_nxt = 1'b0;
					mode_nxt = rwc_pkg::RWC_RUN;
				end
			end
		endcase
	end

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			to_r <= rwc_pkg::RST_TIMEOUT;
			pd_r <= rwc_pkg::RST_POWERDOWN;
			mode_r <= rwc_pkg::RWC_RUN;
			crst_r <= 1'b1;
		end else begin
			to_r <= to_nxt;
			pd_r <= pd_nxt;
			mode_r <= mode_nxt;
			crst_r <= crst_nxt;
		end
	end

	// flags read straight from their flops at all times
	assign o_timeout_flag = to_r;
	assign o_powerdown_flag = pd_r;
	assign o_sleeping = (mode_r == rwc_pkg::RWC_SLEEP);
	assign o_core_reset = crst_r;

	// named steps shared by the checks below
	sequence wd_in_run_s;
		mode_r == rwc_pkg::RWC_RUN && !pin_rst && i_watchdog_timer_timeout;
	endsequence

	sequence wd_in_sleep_s;
		o_sleeping && !pin_rst && i_watchdog_timer_timeout;
	endsequence

	sequence change_in_sleep_s;
		o_sleeping && !pin_rst && !i_watchdog_timer_timeout
		&& i_pin_change_wake;
	endsequence

	sequence no_event_s;
		!pin_rst && !i_watchdog_timer_timeout && !i_pin_change_wake
		&& !i_sleep_instr && !i_watchdog_clear_instr;
	endsequence

	// low then high on the pin is one pin reset
	sequence pin_low_high_s;
		!i_reset_pin_n ##1 i_reset_pin_n;
	endsequence

	run_pin_keep_a: assert property (@(posedge i_clk)
		disable iff (i_sys_rst)
		(mode_r == rwc_pkg::RWC_RUN && pin_rst)
		|=> $stable(to_r) && $stable(pd_r) && !o_sleeping)
		else $error("pin reset in run changed flags");
	sleep_pin_wake_a: assert property (@(posedge i_clk)
		disable iff (i_sys_rst)
		(mode_r == rwc_pkg::RWC_SLEEP && pin_rst)
		|=> to_r && !pd_r && !o_sleeping)
		else $error("pin wake flags wrong");
	run_wd_a: assert property (@(posedge i_clk)
		disable iff (i_sys_rst)
		wd_in_run_s |=> !to_r && $stable(pd_r) && !o_sleeping)
		else $error("watchdog in run flags wrong");
	sleep_wd_a: assert property (@(posedge i_clk)
		disable iff (i_sys_rst)
		wd_in_sleep_s |=> !to_r && !pd_r && !o_sleeping)
		else $error("watchdog wake flags wrong");
	change_wake_a: assert property (@(posedge i_clk)
		disable iff (i_sys_rst)
		change_in_sleep_s |=> to_r && !pd_r && !o_sleeping)
		else $error("pin change wake flags wrong");
	run_change_a: assert property (@(posedge i_clk)
		disable iff (i_sys_rst)
		(!o_sleeping && !pin_rst && !i_watchdog_timer_timeout
		&& !i_sleep_instr && !i_watchdog_clear_instr && i_pin_change_wake)
		|=> $stable(to_r) && $stable(pd_r) && !o_sleeping)
		else $error("pin change acted while running");
	clear_instr_a: assert property (@(posedge i_clk)
		disable iff (i_sys_rst)
		(!o_sleeping && !pin_rst && !i_watchdog_timer_timeout
		&& !i_sleep_instr && i_watchdog_clear_instr)
		|=> to_r && pd_r)
		else $error("clear instruction flags wrong");
	sleep_instr_a: assert property (@(posedge i_clk)
		disable iff (i_sys_rst)
		(!o_sleeping && !pin_rst && !i_watchdog_timer_timeout
		&& i_sleep_instr)
		|=> to_r && !pd_r && o_sleeping)
		else $error("sleep instruction flags wrong");
	core_reset_a: assert property (@(posedge i_clk)
		disable iff (i_sys_rst)
		(pin_rst || i_watchdog_timer_timeout) |=> o_core_reset)
		else $error("reset source did not reset core");
	core_quiet_a: assert property (@(posedge i_clk)
		disable iff (i_sys_rst)
		(!pin_rst && !i_watchdog_timer_timeout) |=> !o_core_reset)
		else $error("core reset without a source");
	pin_pulse_a: assert property (@(posedge i_clk)
		disable iff (i_sys_rst)
		pin_low_high_s |=> pin_rst)
		else $error("pin pulse not taken");
	pin_low_a: assert property (@(posedge i_clk)
		disable iff (i_sys_rst)
		!i_reset_pin_n |=> !pin_rst)
		else $error("pin reset while pin still low");
	quiet_hold_a: assert property (@(posedge i_clk)
		disable iff (i_sys_rst)
		no_event_s |=> $stable(to_r) && $stable(pd_r))
		else $error("flags changed without event");
	// instructions are not executed while asleep, so only wakes move it
	sleep_hold_a: assert property (@(posedge i_clk)
		disable iff (i_sys_rst)
		(o_sleeping && !pin_rst && !i_watchdog_timer_timeout
		&& !i_pin_change_wake)
		|=> $stable(to_r) && $stable(pd_r) && o_sleeping)
		else $error("sleep left without wake event");
	// no disable here: this looks at the first edge after release
	power_on_a: assert property (@(posedge i_clk)
		$fell(i_sys_rst) |-> to_r && pd_r && !o_sleeping)
		else $error("power-on flag values wrong");
endmodule : rwc_flags
`default_nettype wire

/* verif/rwc_flags_tb.sv */
// rwc_flags_tb: self-checking bench for the reset and wake cause flags
// assumes rwc_flags results settle one edge after a pulse is sampled
`timescale 1ns/1ps
`default_nettype none
module rwc_flags_tb;
	logic i_clk = 1'h0;
	logic i_sys_rst = 1'h1;
	logic i_reset_pin_n = 1'h1;
	// watchdog, pin change, clear instr, sleep instr
	logic [3:0] ev = 4'h0;
	logic o_timeout_flag, o_powerdown_flag, o_sleeping, o_core_reset;
	// model state: core reset, sleeping, timeout, powerdown
	logic [3:0] m = 4'h3;
	logic [3:0] exp_q[$];
	int failures = 0;
	int check_count = 0;
	int op;
	event res_ev;
	int plan[10] = '{4, 0, 0, 4, 1, 1, 4, 2, 2, 3};

	always #20 i_clk = ~i_clk;

	rwc_flags i_rwc_flags (
		.i_clk(i_clk),
		.i_sys_rst(i_sys_rst),
		.i_reset_pin_n(i_reset_pin_n),
		.i_watchdog_timer_timeout(ev[3]),
		.i_pin_change_wake(ev[2]),
		.i_watchdog_clear_instr(ev[1]),
		.i_sleep_instr(ev[0]),
		.o_timeout_flag(o_timeout_flag),
		.o_powerdown_flag(o_powerdown_flag),
		.o_sleeping(o_sleeping),
		.o_core_reset(o_core_reset)
	);

	task automatic cmp_state(input logic [3:0] got, input logic [3:0] want);
		check_count++;
		if (got !== want) begin
			failures++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, want);
		end
	endtask : cmp_state

	task automatic complete_run;
		if (failures == 0 && check_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : complete_run

	always @(res_ev) begin
		cmp_state({o_core_reset, o_sleeping, o_timeout_flag, o_powerdown_flag},
			exp_q.pop_front());
	end

	task automatic note(input logic [3:0] v);
		exp_q.push_back(v);
		-> res_ev;
	endtask : note

	// ops: 0 pin reset, 1 watchdog, 2 pin change, 3 clear, 4 sleep
	task automatic run_op(input int o);
		logic [3:0] e;
		if (o == 0) begin
			i_reset_pin_n <= 1'h0;
			@(posedge i_clk);
			i_reset_pin_n <= 1'h1;
			repeat (2) @(posedge i_clk);
		end else begin
			ev[4 - o] <= 1'h1;
			@(posedge i_clk);
			ev <= 4'h0;
		end
		case (o)
			0: e = m[2] ? 4'hA : {2'h2, m[1:0]};
			1: e = m[2] ? 4'h8 : {3'h4, m[0]};
			2: e = m[2] ? 4'h2 : {2'h0, m[1:0]};
			3: e = 4'h3;
			default: e = 4'h6;
		endcase
		m = e;
		@(negedge i_clk);
		note(e);
	endtask : run_op

	initial begin
		void'($urandom(21));
		// a declared start value makes no reset edge, so let one clock
		// edge load the reset values before the first look
		@(posedge i_clk);
		@(negedge i_clk);
		note(4'hB);
		repeat (2) @(posedge i_clk);
		i_sys_rst <= 1'h0;
		@(posedge i_clk);
		@(negedge i_clk);
		note(4'h3);
		for (int k = 0; k < 210; k++) begin
			op = (k < 10) ? plan[k] : int'($urandom_range(4));
			// instructions do not run while asleep
			if (m[2] && op > 2) op = op - 3;
			@(posedge i_clk);
			run_op(op);
		end
		@(posedge i_clk);
		run_op(4);
		@(posedge i_clk);
		i_sys_rst <= 1'h1;
		@(negedge i_clk);
		note(4'hB);
		@(posedge i_clk);
		i_sys_rst <= 1'h0;
		@(posedge i_clk);
		@(negedge i_clk);
		note(4'h3);
		@(posedge i_clk);
		complete_run();
	end

	// about 500 cycles expected; the limit leaves wide margin
	initial begin
		#200000;
		failures++;
		complete_run();
	end
endmodule : rwc_flags_tb
`default_nettype wire
